// ---- rtb_framer.sv ----
// Receiver tuning and Type B framing: two byte registers, the
// transmit marker and character generator, the receive byte assembler.
// Assumes fc_tick, bit strobes and register strobes share clk.
`timescale 1ns/10ps
`default_nettype none

module rtb_framer
  import rtb_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port
  input wire logic [5:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Adjust bit held in another register
  input wire logic frame_marker_adjust,
  // Carrier-rate enable
  input wire logic fc_tick,
  // Transmit byte stream and line bit
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready,
  output logic tx_bit,
  // Receive decoder events
  input wire logic rx_sof,
  input wire logic rx_bit_valid,
  input wire logic rx_bit,
  input wire logic rx_eof,
  input wire logic rx_end,
  input wire logic [1:0] rx_mode,
  output logic rx_byte_valid,
  output logic [7:0] rx_byte,
  output logic rx_parity_err,
  output logic rx_proto_err,
  // Analog receiver controls
  output logic miller_filter_fast,
  output logic wide_recovery_pll,
  output logic [1:0] highpass_corner,
  output logic module_output_delay,
  // Secure module signal path
  input wire logic module_signal_src,
  output logic module_signal_out
);

  logic [7:0] rcv_r, typb_r, reg_rdata_r, rd_val;
  logic wr_rcv, wr_typb, cfg_upd;
  logic miller_filter_fast_r, wide_recovery_pll_r, module_output_delay_r;
  logic [1:0] highpass_corner_r, corner_nxt;
  logic module_signal_out_r, dly_bit;
  rtb_tx_cfg_t tx_live, tx_cfg_r, tx_use;
  rtb_rx_cfg_t rx_live, rx_cfg_r, rx_use;
  rtb_tx_state_t tx_st, tx_st_nxt;
  rtb_rx_state_t rx_st, rx_st_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_load, ph_r;
  logic cnt_done, tx_reload, tx_take, tx_ready_r, tx_bit_r, bit_val;
  logic last_r, char_bit;
  logic [7:0] data_r;
  logic [3:0] bidx_r, char_last_idx;
  logic [7:0] sh_r, sh_in;
  logic [3:0] bcnt_r;
  logic eof_seen_r, rx_take, byte_done, par_bad;
  logic rx_byte_valid_r, rx_parity_err_r, rx_proto_err_r;
  logic [7:0] rx_byte_r;

  // Register decode; reserved bits are never stored
  assign wr_rcv = reg_wr && (reg_addr == RCV_TUNE_ADDR);
  assign wr_typb = reg_wr && (reg_addr == TYPEB_ADDR);
  assign rd_val = (reg_addr == RCV_TUNE_ADDR) ? rcv_r :
                  (reg_addr == TYPEB_ADDR) ? typb_r : 8'h00;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rcv_r <= RCV_TUNE_RST;
      typb_r <= TYPEB_RST;
      reg_rdata_r <= 8'h00;
    end else begin
      if (wr_rcv) rcv_r <= reg_wdata & RCV_TUNE_WMASK;
      if (wr_typb) typb_r <= reg_wdata & TYPEB_WMASK;
      if (reg_rd) reg_rdata_r <= rd_val;
    end
  end

  // Analog controls follow the register only while no frame runs
  assign cfg_upd = (tx_st == T_IDLE) && (rx_st == R_IDLE);
  assign corner_nxt = rcv_r[RCV_MANUAL_BIT] ?
    rcv_r[RCV_CORNER_LSB +: 2] : rx_mode;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      miller_filter_fast_r <= 1'b0;
      wide_recovery_pll_r <= 1'b0;
      module_output_delay_r <= 1'b0;
      highpass_corner_r <= CORNER_106K;
    end else if (cfg_upd) begin
      miller_filter_fast_r <= rcv_r[RCV_FAST_BIT];
      wide_recovery_pll_r <= rcv_r[RCV_WIDE_PLL_BIT];
      module_output_delay_r <= rcv_r[RCV_DELAY_BIT];
      highpass_corner_r <= corner_nxt;
    end
  end

  // Delayed copy lets the module answer later; bypass costs nothing
  rtb_delay_line #(.DEPTH(OUT_DELAY_FC), .AW(7)) u_dly (
    .clk(clk),
    .rst_b(rst_b),
    .adv(fc_tick),
    .din(module_signal_src),
    .dout(dly_bit)
  );

  always_ff @(posedge clk) begin
    if (!rst_b) module_signal_out_r <= 1'b0;
    else module_signal_out_r <= module_output_delay_r ? dly_bit
                                                      : module_signal_src;
  end

  // Live settings; snapshots are taken as a frame begins
  assign tx_live = '{par_off: rcv_r[RCV_PAR_OFF_BIT],
                     width: typb_r[TB_WIDTH_BIT],
                     adjust: frame_marker_adjust,
                     no_sof: typb_r[TB_NO_SOF_BIT],
                     no_eof: typb_r[TB_NO_EOF_BIT],
                     egt: typb_r[TB_EGT_LSB +: 2]};
  assign rx_live = '{par_off: rcv_r[RCV_PAR_OFF_BIT],
                     sof_req: typb_r[TB_SOF_REQ_BIT],
                     eof_req: typb_r[TB_EOF_REQ_BIT]};
  assign tx_use = (tx_st == T_IDLE) ? tx_live : tx_cfg_r;
  assign rx_use = (rx_st == R_IDLE) ? rx_live : rx_cfg_r;

  // Transmit sequencing
  assign cnt_done = fc_tick && (cnt_r == CNT_W'(1));
  assign tx_take = (tx_st == T_LOAD) && tx_valid && tx_ready_r;
  assign char_last_idx = CHAR_STOP_IDX + {3'h0, ~tx_cfg_r.par_off}
                       + {2'h0, tx_cfg_r.egt};
  assign tx_reload = (tx_st_nxt != tx_st) ||
                     ((tx_st == T_CHAR) && cnt_done);

  always_comb begin
    tx_st_nxt = tx_st;
    unique case (tx_st)
      T_IDLE: if (tx_valid) tx_st_nxt = tx_live.no_sof ? T_LOAD
                                                       : T_SOF_LO;
      T_SOF_LO: if (cnt_done) tx_st_nxt = T_SOF_HI;
      T_SOF_HI: if (cnt_done) tx_st_nxt = T_LOAD;
      T_LOAD: if (tx_take) tx_st_nxt = T_CHAR;
      T_CHAR: if (cnt_done && (bidx_r == char_last_idx)) begin
        if (!last_r) tx_st_nxt = T_LOAD;
        else tx_st_nxt = tx_cfg_r.no_eof ? T_IDLE : T_EOF_LO;
      end
      T_EOF_LO: if (cnt_done) tx_st_nxt = T_IDLE;
    endcase
  end

  // Phase lengths in carrier ticks
  always_comb begin
    cnt_load = '0;
    unique case (tx_st_nxt)
      T_SOF_LO: cnt_load = rtb_marker_low(tx_use.width,
                                          tx_use.adjust);
      T_SOF_HI: cnt_load = rtb_marker_high(tx_use.width,
                                           tx_use.adjust);
      T_EOF_LO: cnt_load = rtb_marker_low(tx_use.width,
                                          tx_use.adjust);
      T_CHAR: cnt_load = ETU_CNT;
      T_IDLE, T_LOAD: cnt_load = '0;
    endcase
  end

  // Odd parity in slot 9 unless parity is off
  assign char_bit = (bidx_r == 4'h0) ? 1'b0 :
                    (bidx_r <= 4'h8) ? data_r[3'(bidx_r - 4'h1)] :
                    (bidx_r == CHAR_STOP_IDX && !tx_cfg_r.par_off) ?
                    ~^data_r : 1'b1;
  assign bit_val = (tx_st == T_SOF_LO || tx_st == T_EOF_LO) ? 1'b0 :
                   (tx_st == T_CHAR) ? char_bit : 1'b1;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_st <= T_IDLE;
      cnt_r <= '0;
      bidx_r <= 4'h0;
      tx_ready_r <= 1'b0;
      tx_bit_r <= 1'b1;
      tx_cfg_r <= '0;
    end else begin
      tx_st <= tx_st_nxt;
      tx_ready_r <= (tx_st_nxt == T_LOAD);
      tx_bit_r <= bit_val;
      if (tx_st == T_IDLE && tx_valid) tx_cfg_r <= tx_live;
      if (tx_reload) cnt_r <= cnt_load;
      else if (fc_tick && cnt_r != '0) cnt_r <= cnt_r - 1'b1;
      if (tx_st_nxt != T_CHAR) bidx_r <= 4'h0;
      else if (tx_st == T_CHAR && cnt_done) bidx_r <= bidx_r + 4'h1;
    end
  end

  // Byte holding register, no reset needed
  always_ff @(posedge clk) begin
    if (tx_take) begin
      data_r <= tx_data;
      last_r <= tx_last;
    end
  end

  // Receive: drop streams lacking a required start marker
  always_comb begin
    rx_st_nxt = rx_st;
    unique case (rx_st)
      R_IDLE: if (rx_sof) rx_st_nxt = R_DATA;
        else if (rx_bit_valid)
          rx_st_nxt = rx_live.sof_req ? R_DROP : R_DATA;
      R_DATA, R_DROP: if (rx_end) rx_st_nxt = R_IDLE;
    endcase
  end

  // Markers never enter the data path; only decoded bits do
  assign rx_take = rx_bit_valid && !eof_seen_r && !rx_end &&
    ((rx_st == R_DATA) ||
     (rx_st == R_IDLE && !rx_sof && !rx_live.sof_req));
  assign byte_done = rx_take &&
    (rx_use.par_off ? (bcnt_r == 4'h7) : (bcnt_r == 4'h8));
  assign sh_in = {rx_bit, sh_r[7:1]};
  assign par_bad = ~(^sh_r ^ rx_bit);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_st <= R_IDLE;
      rx_cfg_r <= '0;
      sh_r <= 8'h00;
      bcnt_r <= 4'h0;
      eof_seen_r <= 1'b0;
      rx_byte_valid_r <= 1'b0;
      rx_byte_r <= 8'h00;
      rx_parity_err_r <= 1'b0;
      rx_proto_err_r <= 1'b0;
    end else begin
      rx_st <= rx_st_nxt;
      if (rx_st == R_IDLE) rx_cfg_r <= rx_live;
      if (rx_st_nxt == R_IDLE) begin
        bcnt_r <= 4'h0;
        eof_seen_r <= 1'b0;
      end else begin
        if (rx_eof && rx_st == R_DATA) eof_seen_r <= 1'b1;
        if (rx_take) begin
          bcnt_r <= byte_done ? 4'h0 : bcnt_r + 4'h1;
          if (bcnt_r != 4'h8) sh_r <= sh_in;
        end
      end
      rx_byte_valid_r <= byte_done;
      if (byte_done) rx_byte_r <= rx_use.par_off ? sh_in : sh_r;
      rx_parity_err_r <= byte_done && !rx_use.par_off && par_bad;
      rx_proto_err_r <= (rx_st == R_DATA) && rx_end &&
        rx_cfg_r.eof_req && !eof_seen_r && !rx_eof;
    end
  end

  // Carrier ticks spent in the current transmit phase
  always_ff @(posedge clk) begin
    if (!rst_b || tx_reload) ph_r <= '0;
    else if (fc_tick) ph_r <= ph_r + 1'b1;
  end

  assign reg_rdata = reg_rdata_r;
  assign tx_ready = tx_ready_r;
  assign tx_bit = tx_bit_r;
  assign rx_byte_valid = rx_byte_valid_r;
  assign rx_byte = rx_byte_r;
  assign rx_parity_err = rx_parity_err_r;
  assign rx_proto_err = rx_proto_err_r;
  assign miller_filter_fast = miller_filter_fast_r;
  assign wide_recovery_pll = wide_recovery_pll_r;
  assign highpass_corner = highpass_corner_r;
  assign module_output_delay = module_output_delay_r;
  assign module_signal_out = module_signal_out_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_sof_lo_end;
    (tx_st == T_SOF_LO) && cnt_done;
  endsequence

  a_parity_off_quiet: assert property (
    rx_take && rx_use.par_off |=> !rx_parity_err_r)
    else $error("parity fault flagged with parity off");
  a_parity_slot_data: assert property (
    rx_take && rx_use.par_off && bcnt_r == 4'h7 |=>
    rx_byte_valid_r && rx_byte_r[7] == $past(rx_bit))
    else $error("parity slot not taken as data");
  a_corner_manual: assert property (
    cfg_upd && rcv_r[RCV_MANUAL_BIT] |=>
    highpass_corner_r == $past(rcv_r[1:0]))
    else $error("manual corner not applied");
  a_fast_filter: assert property (
    cfg_upd |=> miller_filter_fast_r == $past(rcv_r[RCV_FAST_BIT]))
    else $error("fast filter control wrong");
  a_reserved_zero: assert property (
    rcv_r[7] == 1'b0 && typb_r[5] == 1'b0)
    else $error("reserved bit stored");
  a_sof_drop: assert property (
    rx_st == R_DROP |=> !rx_byte_valid_r)
    else $error("byte delivered from dropped stream");
  a_eof_missing: assert property (
    rx_st == R_DATA && rx_end && rx_cfg_r.eof_req && !eof_seen_r &&
    !rx_eof |=> rx_proto_err_r)
    else $error("missing end marker not flagged");
  a_eof_optional: assert property (
    rx_st == R_DATA && !rx_cfg_r.eof_req |=> !rx_proto_err_r)
    else $error("protocol error with end optional");
  a_sof_low_len: assert property (
    s_sof_lo_end |-> ph_r + 1'b1 ==
    rtb_marker_low(tx_cfg_r.width, tx_cfg_r.adjust))
    else $error("start marker low length wrong");
  a_sof_high_len: assert property (
    (tx_st == T_SOF_HI) && cnt_done |-> ph_r + 1'b1 ==
    rtb_marker_high(tx_cfg_r.width, tx_cfg_r.adjust))
    else $error("start marker high length wrong");
  a_no_sof_tx: assert property (
    tx_st == T_IDLE && tx_valid && tx_live.no_sof |=> tx_st == T_LOAD)
    else $error("start marker sent while suppressed");
  a_no_eof_tx: assert property (
    tx_st == T_CHAR && tx_cfg_r.no_eof |=> tx_st != T_EOF_LO)
    else $error("end marker sent while suppressed");

endmodule
`default_nettype wire

// ---- rtb_pkg.sv ----
// Constants, types and decoders shared by the receiver tuning and
// Type B framing block.
// Assumes a 20 MHz clk and a carrier-rate tick from same-clock logic.

package rtb_pkg;

  // Register offsets, reset values and writable bits
  localparam logic [5:0] RCV_TUNE_ADDR = 6'h1d;
  localparam logic [5:0] TYPEB_ADDR = 6'h1e;
  localparam logic [7:0] RCV_TUNE_RST = 8'h00;
  localparam logic [7:0] TYPEB_RST = 8'h00;
  localparam logic [7:0] RCV_TUNE_WMASK = 8'h7f;
  localparam logic [7:0] TYPEB_WMASK = 8'hdf;

  // Field positions, receiver tuning register
  localparam int RCV_FAST_BIT = 6;
  localparam int RCV_DELAY_BIT = 5;
  localparam int RCV_PAR_OFF_BIT = 4;
  localparam int RCV_WIDE_PLL_BIT = 3;
  localparam int RCV_MANUAL_BIT = 2;
  localparam int RCV_CORNER_LSB = 0;

  // Field positions, Type B register
  localparam int TB_SOF_REQ_BIT = 7;
  localparam int TB_EOF_REQ_BIT = 6;
  localparam int TB_WIDTH_BIT = 4;
  localparam int TB_NO_SOF_BIT = 3;
  localparam int TB_NO_EOF_BIT = 2;
  localparam int TB_EGT_LSB = 0;

  // High-pass corner codes
  localparam logic [1:0] CORNER_106K = 2'h0;
  localparam logic [1:0] CORNER_212K = 2'h1;
  localparam logic [1:0] CORNER_424K = 2'h2;
  localparam logic [1:0] CORNER_848K = 2'h3;

  // Timing, counted in carrier ticks (fc)
  localparam int CNT_W = 11;
  localparam int ETU_FC = 128;
  localparam int SOF_LO_MIN_ETU = 10;
  localparam int SOF_LO_MAX_ETU = 11;
  localparam int SOF_HI_MIN_ETU = 2;
  localparam int SOF_HI_MAX_ETU = 3;
  localparam int ADJ_FC = 8;
  localparam int OUT_DELAY_FC = 128;
  localparam logic [CNT_W-1:0] ETU_CNT = CNT_W'(ETU_FC);
  localparam logic [CNT_W-1:0] LO_MIN_CNT = CNT_W'(SOF_LO_MIN_ETU*ETU_FC);
  localparam logic [CNT_W-1:0] LO_MAX_CNT = CNT_W'(SOF_LO_MAX_ETU*ETU_FC);
  localparam logic [CNT_W-1:0] LO_ADJ_CNT =
    CNT_W'(SOF_LO_MAX_ETU*ETU_FC-ADJ_FC);
  localparam logic [CNT_W-1:0] HI_MIN_CNT = CNT_W'(SOF_HI_MIN_ETU*ETU_FC);
  localparam logic [CNT_W-1:0] HI_MAX_CNT = CNT_W'(SOF_HI_MAX_ETU*ETU_FC);
  localparam logic [CNT_W-1:0] HI_ADJ_CNT =
    CNT_W'(SOF_HI_MIN_ETU*ETU_FC+ADJ_FC);

  // Character layout: start, 8 data, parity slot, stop, guard
  localparam logic [3:0] CHAR_STOP_IDX = 4'h9;

  typedef enum logic [2:0] {
    T_IDLE, T_SOF_LO, T_SOF_HI, T_LOAD, T_CHAR, T_EOF_LO
  } rtb_tx_state_t;

  typedef enum logic [1:0] {R_IDLE, R_DATA, R_DROP} rtb_rx_state_t;

  typedef struct packed {
    logic par_off;
    logic width;
    logic adjust;
    logic no_sof;
    logic no_eof;
    logic [1:0] egt;
  } rtb_tx_cfg_t;

  typedef struct packed {
    logic par_off;
    logic sof_req;
    logic eof_req;
  } rtb_rx_cfg_t;

  // Low part of start marker, also end marker low part
  function automatic logic [CNT_W-1:0] rtb_marker_low(
    input logic width, input logic adjust);
    logic [CNT_W-1:0] len;
    len = LO_MIN_CNT;
    if (width && adjust) len = LO_ADJ_CNT;
    else if (width) len = LO_MAX_CNT;
    return len;
  endfunction

  // High part of start marker
  function automatic logic [CNT_W-1:0] rtb_marker_high(
    input logic width, input logic adjust);
    logic [CNT_W-1:0] len;
    len = HI_MIN_CNT;
    if (width && adjust) len = HI_ADJ_CNT;
    else if (width) len = HI_MAX_CNT;
    return len;
  endfunction

endpackage

// ---- rtb_delay_line.sv ----
// Single-bit delay line clocked by an advance enable.
// Assumes adv comes from the same clock domain as clk.
`timescale 1ns/10ps
`default_nettype none

module rtb_delay_line #(
  parameter int DEPTH = 128,
  parameter int AW = 7
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Sample stream
  input wire logic adv,
  input wire logic din,
  output logic dout
);

  logic [DEPTH-1:0] mem;
  logic [AW-1:0] ptr_r;
  logic dout_r;

  // Read the oldest sample before it is overwritten
  always_ff @(posedge clk) begin
    if (adv) begin
      mem[ptr_r] <= din;
    end
  end

  // Pointer wraps over the whole depth, so delay equals DEPTH advances
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ptr_r <= '0;
      dout_r <= 1'b0;
    end else if (adv) begin
      ptr_r <= (ptr_r == AW'(DEPTH-1)) ? '0 : ptr_r + 1'b1;
      dout_r <= mem[ptr_r];
    end
  end

  assign dout = dout_r;

endmodule
`default_nettype wire

// ---- rtb_rf_peer.sv ----
// RF peer model: receive decoder event source and transmit line monitor.
// Assumes one clock; events change just after the falling edge.
`timescale 1ns/10ps
`default_nettype none

module rtb_rf_peer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic fc_tick,
  // Decoder events
  output logic rx_sof,
  output logic rx_bit_valid,
  output logic rx_bit,
  output logic rx_eof,
  output logic rx_end,
  // Line runs: level and length in carrier ticks
  input wire logic tx_bit,
  output logic run_valid,
  output logic [16:0] run_info
);
  logic lvl_r;
  logic [15:0] cnt_r;

  initial begin
    {rx_sof, rx_bit_valid, rx_bit, rx_eof, rx_end} = 5'h00;
  end

  // One event pulse, then a gap; the idle data line shows the inverse
  task automatic ev(input int sel, input logic b, input int gap);
    @(negedge clk);
    rx_bit = b;
    rx_sof = (sel == 0);
    rx_bit_valid = (sel == 1);
    rx_eof = (sel == 2);
    rx_end = (sel == 3);
    @(negedge clk);
    {rx_sof, rx_bit_valid, rx_eof, rx_end} = 4'h0;
    rx_bit = ~b;
    repeat (gap) @(negedge clk);
  endtask

  // Stream: optional start marker, bits LSB first, optional end marker
  task automatic send_stream(input logic s, input logic [17:0] b,
    input int n, input logic e);
    int i;
    if (s) ev(0, 1'b0, 1);
    for (i = 0; i < n; i++) ev(1, b[i], i % 3);
    if (e) ev(2, 1'b1, 2);
    ev(3, 1'b0, 1);
  endtask

  // Measure each run of equal line level, reported when it ends
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lvl_r <= 1'b1;
      cnt_r <= 16'h0000;
      run_valid <= 1'b0;
      run_info <= 17'h00000;
    end else begin
      run_valid <= 1'b0;
      if (tx_bit != lvl_r) begin
        run_valid <= 1'b1;
        run_info <= {lvl_r, cnt_r};
        lvl_r <= tx_bit;
        cnt_r <= {15'h0000, fc_tick};
      end else if (fc_tick) begin
        cnt_r <= cnt_r + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// ---- rtb_framer_tb.sv ----
// Self-checking bench for the tuning and Type B framing block.
// Assumes the carrier tick runs every cycle, so one tick is one clock.
`timescale 1ns/10ps
`default_nettype none

module rtb_framer_tb
  import rtb_pkg::*;
();
  logic clk, rst_b, reg_wr, reg_rd, adj, fc_tick, tx_valid, tx_last;
  logic tx_ready, tx_bit, src, src_out, run_valid, chk_src;
  logic rx_sof, rx_bv, rx_b, rx_eof, rx_end, rx_bval, rx_perr, rx_proto;
  logic fast, pll, dly_on;
  logic [1:0] rx_mode, corner;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, tx_data, rx_byte, r;
  logic [16:0] run_info, e;
  logic [10:0] f;
  logic [255:0] hist;
  logic [16:0] runq[$];
  logic [10:0] rxq[$];
  int error_cnt = 0;
  int checks_done = 0;
  int seed = 94332;
  int dly = 0;
  int i;

  rtb_framer u_dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .frame_marker_adjust(adj), .fc_tick(fc_tick),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_ready(tx_ready), .tx_bit(tx_bit), .rx_sof(rx_sof),
    .rx_bit_valid(rx_bv), .rx_bit(rx_b), .rx_eof(rx_eof), .rx_end(rx_end),
    .rx_mode(rx_mode), .rx_byte_valid(rx_bval), .rx_byte(rx_byte),
    .rx_parity_err(rx_perr), .rx_proto_err(rx_proto),
    .miller_filter_fast(fast), .wide_recovery_pll(pll),
    .highpass_corner(corner), .module_output_delay(dly_on),
    .module_signal_src(src), .module_signal_out(src_out));

  rtb_rf_peer u_peer (.clk(clk), .rst_b(rst_b), .fc_tick(fc_tick),
    .rx_sof(rx_sof), .rx_bit_valid(rx_bv), .rx_bit(rx_b), .rx_eof(rx_eof),
    .rx_end(rx_end), .tx_bit(tx_bit), .run_valid(run_valid),
    .run_info(run_info));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input string w, input logic [16:0] x,
    input logic [16:0] g);
    checks_done++;
    if (g !== x) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", w, x, g);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask

  // Expected line runs of a one-byte frame, then send it
  task automatic tx_frame(input logic [7:0] tb, input logic po, input logic a);
    logic [16:0] sg[$];
    logic [7:0] d;
    int lo, hi, k;
    d = 8'($random(seed));
    wr(RCV_TUNE_ADDR, {3'h0, po, 4'h0});
    wr(TYPEB_ADDR, tb);
    adj = a;
    lo = tb[4] ? 11 * ETU_FC - (a ? ADJ_FC : 0) : 10 * ETU_FC;
    hi = tb[4] ? (a ? 2 * ETU_FC + ADJ_FC : 3 * ETU_FC) : 2 * ETU_FC;
    if (!tb[3]) sg = '{{1'b0, 16'(lo)}, {1'b1, 16'(hi)}};
    sg.push_back({1'b0, 16'(ETU_FC)});
    for (k = 0; k < 8; k++) sg.push_back({d[k], 16'(ETU_FC)});
    if (!po) sg.push_back({~^d, 16'(ETU_FC)});
    sg.push_back({1'b1, 16'(ETU_FC * (1 + tb[1:0]))});
    if (!tb[2]) sg.push_back({1'b0, 16'(lo)});
    sg.push_back(17'h10000);
    // A run that runs into open idle has no fixed length
    foreach (sg[j]) begin
      if (runq[$][16] !== sg[j][16])
        runq.push_back(sg[j]);
      else if (runq[$][15:0] == 16'h0000 || sg[j][15:0] == 16'h0000)
        runq[$][15:0] = 16'h0000;
      else
        runq[$][15:0] = runq[$][15:0] + sg[j][15:0];
    end
    @(negedge clk);
    tx_valid = 1'b1;
    tx_data = d;
    tx_last = 1'b1;
    k = 0;
    // Adjust flips once the frame has started; snapshot must hold
    do begin
      @(negedge clk);
      adj = ~a;
      k++;
    end while (tx_ready !== 1'b1 && k < 4000);
    chk("tx ready", 1, tx_ready);
    @(negedge clk);
    tx_valid = 1'b0;
    repeat (5000) @(negedge clk);
  endtask

  // Expected receive results of one stream, then let the peer send it
  task automatic rx_case(input logic [7:0] tb, input logic po, input logic s,
    input int n, input logic en);
    logic [17:0] b;
    int p, k;
    b = 18'($random(seed));
    wr(RCV_TUNE_ADDR, {3'h0, po, 4'h0});
    wr(TYPEB_ADDR, tb);
    p = po ? 8 : 9;
    if (!(tb[7] && !s)) begin
      for (k = 0; (k + 1) * p <= n; k++)
        rxq.push_back({2'b01, !po && !(^b[k * p +: 9]), b[k * p +: 8]});
      if (tb[6] && !en) rxq.push_back(11'h400);
    end
    u_peer.send_stream(s, b, n, en);
    repeat (4) @(negedge clk);
  endtask

  // Watchers: line runs, receive results, module signal path
  always @(negedge clk) begin
    if (run_valid === 1'b1) begin
      e = (runq.size() > 0) ? runq.pop_front() : 17'h1ffff;
      if (e[15:0] == 16'h0000 || (run_info[15:0] + 16'h0002 >= e[15:0] &&
          run_info[15:0] <= e[15:0] + 16'h0002))
        e[15:0] = run_info[15:0];
      chk("tx run", e, run_info);
    end
    if (rx_bval === 1'b1 || rx_proto === 1'b1) begin
      f = (rxq.size() > 0) ? rxq.pop_front() : 11'h7ff;
      chk("rx result", f, {rx_proto, rx_bval, rx_perr,
        rx_bval ? rx_byte : 8'h00});
    end
    hist = {hist[254:0], src};
    if (chk_src) chk("module out", hist[dly], src_out);
    src = 1'($random(seed));
  end

  task automatic report_and_stop();
    chk("runs left", 1, 17'(runq.size()));
    chk("rx left", 0, 17'(rxq.size()));
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #(100000 * 50);
    error_cnt++;
    report_and_stop();
  end

  initial begin
    {reg_wr, reg_rd, adj, tx_valid, tx_last, src, chk_src} = 7'h00;
    {reg_addr, reg_wdata, tx_data, rx_mode, hist} = '0;
    fc_tick = 1'b1;
    rst_b = 1'b0;
    runq.push_back(17'h10000);
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    rd(RCV_TUNE_ADDR, r);
    chk("tune reset", 0, r);
    rd(TYPEB_ADDR, r);
    chk("typeb reset", 0, r);
    wr(6'h1f, 8'hff);
    rd(6'h1f, r);
    chk("unmapped", 0, r);
    wr(TYPEB_ADDR, 8'hff);
    rd(TYPEB_ADDR, r);
    chk("typeb rsvd", 8'hdf, r);
    $display("test registers done");
    // Fast filter set at random: no long Miller pulses are modelled
    for (i = 0; i < 12; i++) begin
      r = 8'($random(seed));
      if (i < 8) r[2:0] = {i < 4, 2'(i)};
      rx_mode = 2'(i);
      wr(RCV_TUNE_ADDR, r);
      rd(RCV_TUNE_ADDR, e[7:0]);
      chk("tune rsvd", r & 8'h7f, e[7:0]);
      chk("fast", r[6], fast);
      chk("pll", r[3], pll);
      chk("delay", r[5], dly_on);
      chk("corner", r[2] ? r[1:0] : rx_mode, corner);
    end
    $display("test controls done");
    // Output source is assumed set to a delay-capable code
    wr(RCV_TUNE_ADDR, 8'h20);
    dly = OUT_DELAY_FC + 1; // Output register after the line adds one clock
    repeat (300) @(negedge clk);
    chk_src = 1'b1;
    repeat (300) @(negedge clk);
    chk_src = 1'b0;
    wr(RCV_TUNE_ADDR, 8'h00);
    dly = 0;
    repeat (3) @(negedge clk);
    chk_src = 1'b1;
    repeat (100) @(negedge clk);
    chk_src = 1'b0;
    $display("test signal path done");
    tx_frame(8'h00, 1'b0, 1'b0);
    tx_frame(8'h11, 1'b1, 1'b0);
    tx_frame(8'h12, 1'b0, 1'b1);
    tx_frame(8'h03, 1'b0, 1'b1);
    tx_frame(8'h08, 1'b0, 1'b0);
    tx_frame(8'h04, 1'b0, 1'b0);
    tx_frame(8'h0c, 1'b1, 1'b0);
    $display("test transmit done");
    rx_case(8'h00, 1'b0, 1'b1, 18, 1'b1);
    rx_case(8'h00, 1'b0, 1'b0, 9, 1'b0);
    rx_case(8'h80, 1'b0, 1'b0, 9, 1'b0);
    rx_case(8'h80, 1'b0, 1'b1, 9, 1'b0);
    rx_case(8'h40, 1'b0, 1'b1, 9, 1'b0);
    rx_case(8'h40, 1'b0, 1'b1, 9, 1'b1);
    rx_case(8'hc0, 1'b1, 1'b1, 16, 1'b1);
    rx_case(8'h00, 1'b1, 1'b0, 12, 1'b0);
    $display("test receive done");
    report_and_stop();
  end
endmodule
`default_nettype wire
